// ### hdl/light_code_expand.sv
// Shifts a value left by a base plus a scale field into a wider zero-filled linear code.
`timescale 1ns/1ps
`default_nettype none

module light_code_expand #(
	parameter int unsigned IN_W       = 20,
	parameter int unsigned OUT_W      = 28,
	parameter int unsigned BASE_SHIFT = 0
) (
	input  wire logic [IN_W-1:0]  i_value,
	input  wire logic [3:0]       i_scale,
	output logic      [OUT_W-1:0] o_code
);

	// The shift is done at OUT_W bits, so anything shifted past the top of the output is dropped.
	always_comb
	begin
		o_code = OUT_W'(i_value) << (BASE_SHIFT + int'(i_scale));
	end

endmodule : light_code_expand

`default_nettype wire

// ### hdl/light_range_pkg.sv
// Shared constants, field layouts and carrier types for the light range result block.
package light_range_pkg;

	// Clock rate in MHz and conversion periods per channel in microseconds.
	localparam int unsigned CLK_FREQ_MHZ = 200;
	localparam int unsigned CONV_CODES   = 12;
	localparam int unsigned CONV_TIME_US [CONV_CODES] = '{
		600, 1000, 1800, 3400, 6500, 12700, 25000, 50000, 100000, 200000, 400000, 800000};

	// Channel count, widths and shifts of the result and threshold formats.
	localparam int unsigned NUM_CHAN       = 4;
	localparam int unsigned SCALE_W        = 4;
	localparam int unsigned VALUE_W        = 20;
	localparam int unsigned UPPER_W        = 12;
	localparam int unsigned LOWER_W        = 8;
	localparam int unsigned LIN_W          = 28;
	localparam int unsigned THR_W          = 36;
	localparam int unsigned THR_BASE_SHIFT = 8;
	localparam int unsigned PERSIST_W      = 4;

	// Scale and period selection codes.
	localparam logic [3:0] RANGE_AUTO   = 4'hC;
	localparam logic [3:0] RANGE_MAX    = 4'h6;
	localparam logic [3:0] CONV_SEL_MAX = 4'hB;

	// Register byte offsets on the APB port.
	localparam logic [7:0] ADDR_CTRL        = 8'h00;
	localparam logic [7:0] ADDR_THR_HIGH    = 8'h04;
	localparam logic [7:0] ADDR_THR_LOW     = 8'h08;
	localparam logic [7:0] ADDR_STATUS      = 8'h0C;
	localparam logic [7:0] ADDR_RESULT_BASE = 8'h10;
	localparam logic [7:0] ADDR_RESULT_END  = 8'h30;

	// Status bit positions.
	localparam int unsigned STAT_FLAG_HIGH = 0;
	localparam int unsigned STAT_FLAG_LOW  = 1;
	localparam int unsigned STAT_BUSY      = 2;

	// Control word, laid out from bit 13 down to bit 0.
	typedef struct packed {
		logic [1:0] mon_ch;
		logic [1:0] persist;
		logic       latch_mode;
		logic       enable;
		logic [3:0] conv_sel;
		logic [3:0] range_sel;
	} ctrl_s;
	localparam int unsigned CTRL_W = 14;

	// Threshold word: scale in bits 15:12, value in bits 11:0.
	typedef struct packed {
		logic [3:0]  scale;
		logic [11:0] value;
	} thr_s;
	localparam int unsigned THR_REG_W = 16;

	// One sample delivered by the converter front end.
	typedef struct packed {
		logic        ovf;
		logic [19:0] value;
	} sample_s;

	// Reset values: automatic scale, 100 ms period, stopped, widest threshold window.
	localparam ctrl_s CTRL_RESET     = 14'h008C;
	localparam thr_s  THR_HIGH_RESET = 16'hBFFF;
	localparam thr_s  THR_LOW_RESET  = 16'h0000;

	typedef enum logic {PH_IDLE, PH_CONV} phase_e;

endpackage : light_range_pkg

// ### hdl/light_range_result.sv
// Scale selection, conversion sequencing, result formatting and threshold flags.
// Operation
// - Range code 0xC selects automatic scaling.
// - Auto scale follows light and previous result.
// - Near bottom: step scale down one/two.
// - Near top: step scale up one.
// - Overflow in auto below max scale aborts, result not stored.
// - After abort below max, raise and retry.
// - Each channel keeps its own auto scale.
// - Codes 0 to 6 fix the scale.
// - Period codes 0-11 give 600us-800ms.
// - Four channels convert in turn.
// - Results hold until next good conversion.
// - Result is scale code plus value.
// - Scale code is the scale used.
// - Value splits into upper 12, lower 8.
// - Linear code is value shifted by scale.
// - Thresholds have 12-bit value, 4-bit scale.
// - Threshold expands by 8 plus scale.
// - Consecutive faults counted before flags set.
// - Persistence code 2 needs four faults.
// - Latched flags clear on status read.
// - Transparent flags hold inside the window.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module light_range_result #(
	parameter int unsigned CYCLES_PER_US   = light_range_pkg::CLK_FREQ_MHZ,
	parameter logic [19:0] FAR_LOW_LIMIT   = 20'h1_0000,
	parameter logic [19:0] NEAR_LOW_LIMIT  = 20'h4_0000,
	parameter logic [19:0] NEAR_HIGH_LIMIT = 20'hC_0000
) (
	input  wire logic        I_REF_CLK,
	input  wire logic        I_RST,
	input  wire logic        I_CE,
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [7:0]  I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	output logic      [31:0] O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	input  wire logic        I_ADC_CLK,
	input  wire logic [19:0] I_ADC_DATA,
	input  wire logic        I_ADC_OVF,
	output logic             O_ADC_START,
	output logic      [1:0]  O_ADC_CHAN,
	output logic      [3:0]  O_ADC_SCALE,
	output logic             O_FLAG_HIGH,
	output logic             O_FLAG_LOW,
	output logic             O_BUSY
);

	typedef struct packed {
		logic                      clk_m;
		logic                      clk_s;
		logic                      clk_d;
		light_range_pkg::sample_s  dat_m;
		light_range_pkg::sample_s  dat_s;
		light_range_pkg::sample_s  smp;
		light_range_pkg::ctrl_s    ctrl;
		light_range_pkg::thr_s     thr_high;
		light_range_pkg::thr_s     thr_low;
		light_range_pkg::phase_e   phase;
		logic [1:0]                chan;
		logic [3:0]                per_sel;
		logic [31:0]               cnt;
		logic [3:0]                cur_scale;
		logic [3:0][3:0]           auto_scale;
		logic [3:0][3:0]           res_scale;
		logic [3:0][19:0]          res_val;
		logic [3:0][27:0]          res_lin;
		logic [3:0]                hi_cnt;
		logic [3:0]                lo_cnt;
		logic                      flag_h;
		logic                      flag_l;
		logic                      start;
		logic                      rd_ok;
		logic                      slverr;
		logic [31:0]               prdata;
	} state_s;

	state_s      s;
	state_s      next_s;
	logic [19:0] store_val;
	logic [27:0] cur_lin;
	logic [35:0] thr_high_code;
	logic [35:0] thr_low_code;
	logic [35:0] mon_code;
	logic [31:0] period;
	logic [3:0]  manual_scale;
	logic [3:0]  need;
	logic [3:0]  next_hi;
	logic [3:0]  next_lo;
	logic [31:0] rd_data;
	logic [1:0]  rd_ch;
	logic        auto_on;
	logic        done;
	logic        abort;
	logic        good;
	logic        hit;
	logic        access;
	logic        stat_rd;
	logic        fault_hi;
	logic        fault_lo;
	logic        hi_fire;
	logic        lo_fire;

	// Saturate an overflowed result at the top of the scale when it must be reported.
	assign store_val = s.smp.ovf ? 20'hF_FFFF : s.smp.value;

	// Linear code of the finished conversion.
	light_code_expand #(
		.IN_W       (light_range_pkg::VALUE_W),
		.OUT_W      (light_range_pkg::LIN_W),
		.BASE_SHIFT (0)
	) u_lin (
		.i_value (store_val),
		.i_scale (s.cur_scale),
		.o_code  (cur_lin)
	);

	// Threshold words expanded with zero fill to compare in the linear domain.
	light_code_expand #(
		.IN_W       (light_range_pkg::UPPER_W),
		.OUT_W      (light_range_pkg::THR_W),
		.BASE_SHIFT (light_range_pkg::THR_BASE_SHIFT)
	) u_thr_high (
		.i_value (s.thr_high.value),
		.i_scale (s.thr_high.scale),
		.o_code  (thr_high_code)
	);

	light_code_expand #(
		.IN_W       (light_range_pkg::UPPER_W),
		.OUT_W      (light_range_pkg::THR_W),
		.BASE_SHIFT (light_range_pkg::THR_BASE_SHIFT)
	) u_thr_low (
		.i_value (s.thr_low.value),
		.i_scale (s.thr_low.scale),
		.o_code  (thr_low_code)
	);

	// Period lookup and conversion events; reserved period codes use the longest one.
	always_comb
	begin
		if (s.ctrl.conv_sel > light_range_pkg::CONV_SEL_MAX)
			period = 32'(light_range_pkg::CONV_TIME_US[11] * CYCLES_PER_US);
		else
			period = 32'(light_range_pkg::CONV_TIME_US[s.ctrl.conv_sel] * CYCLES_PER_US);
		auto_on      = s.ctrl.range_sel == light_range_pkg::RANGE_AUTO;
		manual_scale = (s.ctrl.range_sel > light_range_pkg::RANGE_MAX) ?
			light_range_pkg::RANGE_MAX : s.ctrl.range_sel;
		done     = (s.phase == light_range_pkg::PH_CONV) && (s.cnt == 32'h0000_0000);
		abort    = done && auto_on && s.smp.ovf &&
			(s.cur_scale < light_range_pkg::RANGE_MAX);
		good     = done && !abort;
		mon_code = {8'h00, cur_lin};
		fault_hi = good && (s.chan == s.ctrl.mon_ch) && (mon_code > thr_high_code);
		fault_lo = good && (s.chan == s.ctrl.mon_ch) && (mon_code < thr_low_code);
		need     = 4'h1 << s.ctrl.persist;
		next_hi  = fault_hi ? ((s.hi_cnt >= 4'h8) ? 4'h8 : s.hi_cnt + 4'h1) : 4'h0;
		next_lo  = fault_lo ? ((s.lo_cnt >= 4'h8) ? 4'h8 : s.lo_cnt + 4'h1) : 4'h0;
		hi_fire  = fault_hi && (next_hi >= need);
		lo_fire  = fault_lo && (next_lo >= need);
	end

	// Register decode. Result words sit in pairs per channel: format word, then linear code.
	always_comb
	begin
		// Result words start at 0x10, so the channel is counted from that base.
		rd_ch   = 2'(I_PADDR[4:3] - 2'd2);
		hit     = 1'b1;
		rd_data = 32'h0000_0000;
		if (I_PADDR[1:0] != 2'b00)
			hit = 1'b0;
		else if (I_PADDR == light_range_pkg::ADDR_CTRL)
			rd_data = 32'(s.ctrl);
		else if (I_PADDR == light_range_pkg::ADDR_THR_HIGH)
			rd_data = 32'(s.thr_high);
		else if (I_PADDR == light_range_pkg::ADDR_THR_LOW)
			rd_data = 32'(s.thr_low);
		else if (I_PADDR == light_range_pkg::ADDR_STATUS)
		begin
			rd_data[light_range_pkg::STAT_FLAG_HIGH] = s.flag_h;
			rd_data[light_range_pkg::STAT_FLAG_LOW]  = s.flag_l;
			rd_data[light_range_pkg::STAT_BUSY]      = s.phase == light_range_pkg::PH_CONV;
		end
		else if (I_PADDR >= light_range_pkg::ADDR_RESULT_BASE &&
			I_PADDR < light_range_pkg::ADDR_RESULT_END)
		begin
			if (I_PADDR[2])
				rd_data = {4'h0, s.res_lin[rd_ch]};
			else
				rd_data = {8'h00, s.res_scale[rd_ch], s.res_val[rd_ch]};
		end
		else
			hit = 1'b0;
	end

	// The read word is captured in the setup cycle, so with the clock enable high the access phase never waits.
	assign access    = I_PSEL && I_PENABLE && s.rd_ok;
	assign O_PREADY  = access && I_CE;
	assign stat_rd   = O_PREADY && !I_PWRITE && (I_PADDR == light_range_pkg::ADDR_STATUS);
	assign O_PRDATA  = s.prdata;
	assign O_PSLVERR = s.slverr;

	// Next-state logic for synchronisers, bus, sequencer and flags.
	always_comb
	begin
		next_s       = s;
		next_s.start = 1'b0;
		next_s.clk_m = I_ADC_CLK;
		next_s.clk_s = s.clk_m;
		next_s.clk_d = s.clk_s;
		next_s.dat_m = {I_ADC_OVF, I_ADC_DATA};
		next_s.dat_s = s.dat_m;
		if (s.clk_s && !s.clk_d)
			next_s.smp = s.dat_s;

		// Bus side.
		if (I_PSEL && !I_PENABLE)
		begin
			next_s.rd_ok  = 1'b1;
			next_s.prdata = rd_data;
			next_s.slverr = !hit;
		end
		if (O_PREADY)
		begin
			next_s.rd_ok = 1'b0;
			if (I_PWRITE && I_PADDR == light_range_pkg::ADDR_CTRL)
				next_s.ctrl = light_range_pkg::ctrl_s'(I_PWDATA[light_range_pkg::CTRL_W-1:0]);
			if (I_PWRITE && I_PADDR == light_range_pkg::ADDR_THR_HIGH)
				next_s.thr_high = light_range_pkg::thr_s'(I_PWDATA[15:0]);
			if (I_PWRITE && I_PADDR == light_range_pkg::ADDR_THR_LOW)
				next_s.thr_low = light_range_pkg::thr_s'(I_PWDATA[15:0]);
		end
		// Reading status releases latched flags; a fault in the same cycle sets them again.
		if (stat_rd && s.ctrl.latch_mode)
		begin
			next_s.flag_h = 1'b0;
			next_s.flag_l = 1'b0;
		end

		// Sequencer.
		if (s.phase == light_range_pkg::PH_IDLE)
		begin
			if (s.ctrl.enable)
			begin
				next_s.phase     = light_range_pkg::PH_CONV;
				next_s.chan      = 2'd0;
				next_s.cur_scale = auto_on ? s.auto_scale[0] : manual_scale;
				next_s.per_sel   = s.ctrl.conv_sel;
				next_s.cnt       = period - 32'h0000_0001;
				next_s.start     = 1'b1;
			end
		end
		else if (!done)
			next_s.cnt = s.cnt - 32'h0000_0001;
		else if (abort)
		begin
			// Retry costs a whole extra period, so a transient stretches the set.
			next_s.auto_scale[s.chan] = s.cur_scale + 4'h1;
			next_s.cur_scale          = s.cur_scale + 4'h1;
			next_s.per_sel            = s.ctrl.conv_sel;
			next_s.cnt                = period - 32'h0000_0001;
			next_s.start              = 1'b1;
		end
		else
		begin
			next_s.res_scale[s.chan] = s.cur_scale;
			next_s.res_val[s.chan]   = store_val;
			next_s.res_lin[s.chan]   = cur_lin;
			if (auto_on)
			begin
				// Stepping is decided per channel from this result alone.
				if (store_val < FAR_LOW_LIMIT)
					next_s.auto_scale[s.chan] = (s.cur_scale > 4'h1) ?
						s.cur_scale - 4'h2 : 4'h0;
				else if (store_val < NEAR_LOW_LIMIT)
					next_s.auto_scale[s.chan] = (s.cur_scale > 4'h0) ?
						s.cur_scale - 4'h1 : 4'h0;
				else if (store_val > NEAR_HIGH_LIMIT && s.cur_scale < light_range_pkg::RANGE_MAX)
					next_s.auto_scale[s.chan] = s.cur_scale + 4'h1;
				else
					next_s.auto_scale[s.chan] = s.cur_scale;
			end
			if (s.chan == s.ctrl.mon_ch)
			begin
				next_s.hi_cnt = next_hi;
				next_s.lo_cnt = next_lo;
				if (s.ctrl.latch_mode)
				begin
					if (hi_fire)
						next_s.flag_h = 1'b1;
					if (lo_fire)
						next_s.flag_l = 1'b1;
				end
				else if (hi_fire || lo_fire)
				begin
					next_s.flag_h = hi_fire;
					next_s.flag_l = lo_fire;
				end
			end
			if (s.ctrl.enable)
			begin
				next_s.chan      = s.chan + 2'd1;
				next_s.cur_scale = auto_on ? s.auto_scale[s.chan + 2'd1] : manual_scale;
				next_s.per_sel   = s.ctrl.conv_sel;
				next_s.cnt       = period - 32'h0000_0001;
				next_s.start     = 1'b1;
			end
			else
				next_s.phase = light_range_pkg::PH_IDLE;
		end
	end

	// State register; the clock enable freezes everything.
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RST)
		begin
			s          <= '0;
			s.ctrl     <= light_range_pkg::CTRL_RESET;
			s.thr_high <= light_range_pkg::THR_HIGH_RESET;
			s.thr_low  <= light_range_pkg::THR_LOW_RESET;
		end
		else if (I_CE)
			s <= next_s;
	end

	assign O_ADC_START = s.start;
	assign O_ADC_CHAN  = s.chan;
	assign O_ADC_SCALE = s.cur_scale;
	assign O_FLAG_HIGH = s.flag_h;
	assign O_FLAG_LOW  = s.flag_l;
	assign O_BUSY      = s.phase == light_range_pkg::PH_CONV;

	// Cycles since the last start, for the period check below.
	logic [31:0] gap;
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RST)
			gap <= 32'h0000_0000;
		else if (I_CE)
			gap <= next_s.start ? 32'h0000_0000 : gap + 32'h0000_0001;
	end

	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (I_RST);

	chk_auto_pick: assert property (I_CE && s.phase == light_range_pkg::PH_IDLE && s.ctrl.enable
		&& auto_on |=> O_ADC_START && O_ADC_SCALE == $past(s.auto_scale[0]))
		else $error("Automatic start did not use the channel scale.");
	chk_manual_fix: assert property (I_CE && done && !auto_on && s.ctrl.enable
		&& s.ctrl.range_sel <= light_range_pkg::RANGE_MAX
		|=> O_ADC_SCALE == $past(s.ctrl.range_sel))
		else $error("Manual scale not applied.");
	chk_step_up: assert property (I_CE && good && auto_on && store_val > NEAR_HIGH_LIMIT
		&& s.cur_scale < light_range_pkg::RANGE_MAX
		|=> s.auto_scale[$past(s.chan)] == $past(s.cur_scale) + 4'h1)
		else $error("Scale did not step up by one.");
	chk_step_down: assert property (I_CE && good && auto_on && store_val < FAR_LOW_LIMIT
		&& s.cur_scale > 4'h1
		|=> s.auto_scale[$past(s.chan)] == $past(s.cur_scale) - 4'h2)
		else $error("Scale did not step down by two.");
	chk_abort_keep: assert property (I_CE && abort |=> $stable(s.res_val) && $stable(s.res_scale)
		&& O_ADC_START && O_ADC_CHAN == $past(s.chan)
		&& O_ADC_SCALE == $past(s.cur_scale) + 4'h1)
		else $error("Overflow result stored or retry missing.");
	chk_period: assert property (I_CE && done
		|-> gap == 32'(light_range_pkg::CONV_TIME_US[(s.per_sel > light_range_pkg::CONV_SEL_MAX) ?
		4'hB : s.per_sel] * CYCLES_PER_US) - 32'h1)
		else $error("Conversion period length wrong.");
	chk_lin_code: assert property (good |-> cur_lin == (28'(store_val) << s.cur_scale))
		else $error("Linear code mismatch.");
	chk_persist: assert property ($rose(s.flag_h) |-> s.hi_cnt >= (4'h1 << s.ctrl.persist))
		else $error("High flag set before persistence count.");
	chk_latch_hold: assert property (s.ctrl.latch_mode && s.flag_h && !stat_rd && I_CE
		|=> s.flag_h)
		else $error("Latched high flag dropped without status read.");
	chk_window_hold: assert property (I_CE && !s.ctrl.latch_mode && !hi_fire && !lo_fire
		|=> $stable({s.flag_h, s.flag_l}))
		else $error("Transparent flags changed without a fault.");

	cov_retry: cover property (I_CE && abort);
	cov_step_up: cover property (I_CE && good && auto_on && store_val > NEAR_HIGH_LIMIT);
	cov_latched: cover property (s.ctrl.latch_mode && $rose(s.flag_l));
	cov_clear: cover property (stat_rd && s.flag_h);

endmodule : light_range_result

`default_nettype wire

// ### tb/light_conv_model.sv
// Behavioural converter front end that answers each conversion start with one sample.
`timescale 1ns/1ps
`default_nettype none

module light_conv_model (
	input  wire logic                           i_clk,
	input  wire logic                           i_start,
	input  wire logic [1:0]                     i_chan,
	input  wire logic [3:0]                     i_scale,
	input  wire logic                           i_auto,
	input  wire logic [15:0]                    i_need,
	input  wire light_range_pkg::sample_s [3:0] i_samples,
	output logic                                o_adc_clk,
	output logic      [19:0]                    o_data,
	output logic                                o_ovf
);
	logic [1:0]               ch;
	logic [3:0]               sc;
	logic [3:0]               need;
	light_range_pkg::sample_s s;

	// In auto mode a scale below the channel's need overflows and one above it reads low.
	// The link clock stands still between samples, and released data shows its inverse.
	initial
	begin
		o_adc_clk = 1'b0;
		o_data = 20'h0_0000;
		o_ovf = 1'b0;
		forever
		begin
			@(posedge i_clk iff i_start);
			ch = i_chan;
			sc = i_scale;
			need = i_need[ch*4 +: 4];
			if (!i_auto)
				s = i_samples[ch];
			else if (sc < need)
				s = {1'b1, 20'h5_A5A5};
			else if (sc > need)
				s = {1'b0, 20'h0_0100};
			else
				s = {1'b0, 20'h8_0000};
			repeat (20) @(posedge i_clk);
			o_data <= s.value;
			o_ovf <= s.ovf;
			repeat (4) @(posedge i_clk);
			#7;
			repeat (3)
			begin
				o_adc_clk = 1'b1;
				#24;
				o_adc_clk = 1'b0;
				#24;
			end
			o_data = ~o_data;
			o_ovf = ~o_ovf;
		end
	end
endmodule : light_conv_model
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench: register access, scale modes, result formats and threshold flags.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic                           clk = 1'b0;
	logic                           rst = 1'b1;
	logic                           psel = 1'b0;
	logic                           penable = 1'b0;
	logic                           pwrite = 1'b0;
	logic [7:0]                     paddr = 8'h00;
	logic [31:0]                    pwdata = 32'h0000_0000;
	logic [31:0]                    prdata;
	logic                           pready;
	logic                           pslverr;
	logic                           adc_clk;
	logic [19:0]                    adc_data;
	logic                           adc_ovf;
	logic                           adc_start;
	logic [1:0]                     adc_chan;
	logic [3:0]                     adc_scale;
	logic                           flag_high;
	logic                           flag_low;
	logic                           busy;
	logic                           ce = 1'b1;
	logic                           auto = 1'b0;
	logic [15:0]                    need = 16'h1502;
	light_range_pkg::sample_s [3:0] samples = '0;
	light_range_pkg::ctrl_s         ctrl;
	logic [33:0]                    note;
	logic [33:0]                    expq [$];
	logic [7:0]                     rb;
	int                             fails = 0;
	int                             comparisons = 0;
	int                             cyc = 0;
	int                             last_start = 0;
	int                             nstart = 0;

	// Free-running reference clock and a cycle count for period checks.
	always #2.5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	light_range_result #(.CYCLES_PER_US(1)) i_dut (
		.I_REF_CLK(clk), .I_RST(rst), .I_CE(ce),
		.I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
		.I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
		.I_ADC_CLK(adc_clk), .I_ADC_DATA(adc_data), .I_ADC_OVF(adc_ovf),
		.O_ADC_START(adc_start), .O_ADC_CHAN(adc_chan), .O_ADC_SCALE(adc_scale),
		.O_FLAG_HIGH(flag_high), .O_FLAG_LOW(flag_low), .O_BUSY(busy)
	);

	light_conv_model i_front (
		.i_clk(clk), .i_start(adc_start), .i_chan(adc_chan), .i_scale(adc_scale),
		.i_auto(auto), .i_need(need), .i_samples(samples),
		.o_adc_clk(adc_clk), .o_data(adc_data), .o_ovf(adc_ovf)
	);

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	// One APB transfer; the expected answer is noted before the request goes out.
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data,
			input logic err, input logic [31:0] exp);
		expq.push_back({wr, err, exp});
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Waits for n conversion starts; in fixed-scale runs also checks spacing and order.
	task automatic starts(input int n, input logic order);
		int waitc;
		repeat (n)
		begin
			waitc = 0;
			do
			begin
				@(posedge clk);
				waitc++;
			end
			while (adc_start !== 1'b1 && waitc < 3000);
			check("start seen", 32'h0000_0001, {31'h0, adc_start});
			if (order && nstart > 0)
				check("start gap", 32'd600, 32'(cyc - last_start));
			if (order)
				check("channel", 32'(nstart % 4), {30'h0, adc_chan});
			if (order)
				check("scale", 32'h3, {28'h0, adc_scale});
			last_start = cyc;
			nstart++;
		end
	endtask : starts

	task automatic end_sim();
		if (fails == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim

	// Each completed transfer is matched against the oldest noted expectation.
	always @(posedge clk)
	begin
		if (psel && penable && pready === 1'b1)
		begin
			note = expq.pop_front();
			check("slave error", {31'h0, note[32]}, {31'h0, pslverr});
			if (!note[33])
				check("read data", note[31:0], prdata);
		end
	end

	// Watchdog sized well above the roughly forty thousand cycles the tests need.
	initial
	begin
		repeat (90000) @(posedge clk);
		fails++;
		end_sim();
	end

	initial
	begin
		void'($urandom(32'h0000_99ab));
		rb = light_range_pkg::ADDR_RESULT_BASE;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, light_range_pkg::ADDR_CTRL, 32'h0, 1'b0, 32'h0000_008C);
		apb(1'b0, light_range_pkg::ADDR_THR_HIGH, 32'h0, 1'b0, 32'h0000_BFFF);
		apb(1'b0, light_range_pkg::ADDR_STATUS, 32'h0, 1'b0, 32'h0000_0000);
		apb(1'b0, 8'h40, 32'h0, 1'b1, 32'h0000_0000);
		apb(1'b1, 8'h02, 32'h0000_1234, 1'b1, 32'h0000_0000);
		// Fixed scale 3, shortest period, channel 1 watched against a low upper limit.
		for (int c = 0; c < 4; c++)
			samples[c].value = 20'($urandom());
		samples[1].value = 20'h0_0400;
		ctrl = light_range_pkg::CTRL_RESET;
		ctrl.range_sel = 4'h3;
		ctrl.conv_sel = 4'h0;
		ctrl.enable = 1'b1;
		ctrl.persist = 2'h2;
		ctrl.mon_ch = 2'h1;
		apb(1'b1, light_range_pkg::ADDR_THR_HIGH, 32'h0000_0010, 1'b0, 32'h0);
		apb(1'b1, light_range_pkg::ADDR_THR_LOW, 32'h0, 1'b0, 32'h0);
		apb(1'b1, light_range_pkg::ADDR_CTRL, {18'h0_0000, ctrl}, 1'b0, 32'h0);
		starts(11, 1'b1);
		repeat (3) @(posedge clk);
		check("flag high early", 32'h0, {31'h0, flag_high});
		starts(4, 1'b1);
		repeat (3) @(posedge clk);
		check("flag high", 32'h1, {31'h0, flag_high});
		check("flag low", 32'h0, {31'h0, flag_low});
		// A low clock enable freezes the running conversion and the flags.
		ce <= 1'b0;
		repeat (8) @(posedge clk);
		check("busy", 32'h1, {31'h0, busy});
		check("frozen flag", 32'h1, {31'h0, flag_high});
		ce <= 1'b1;
		// Latched mode: the first status read shows the flag and clears it, the second sees it gone.
		ctrl.latch_mode = 1'b1;
		apb(1'b1, light_range_pkg::ADDR_CTRL, {18'h0_0000, ctrl}, 1'b0, 32'h0);
		apb(1'b0, light_range_pkg::ADDR_STATUS, 32'h0, 1'b0, 32'h0000_0005);
		apb(1'b0, light_range_pkg::ADDR_STATUS, 32'h0, 1'b0, 32'h0000_0004);
		for (int c = 0; c < 4; c++)
		begin
			apb(1'b0, 8'(rb + 8*c), 32'h0, 1'b0, {12'h003, samples[c].value});
			apb(1'b0, 8'(rb + 8*c + 4), 32'h0, 1'b0, {9'h000, samples[c].value, 3'h0});
		end
		samples[0].value = ~samples[0].value;
		apb(1'b0, 8'(rb + 4), 32'h0, 1'b0, {9'h000, ~samples[0].value, 3'h0});
		// Automatic scale with a different settling scale on each channel.
		auto = 1'b1;
		ctrl.range_sel = light_range_pkg::RANGE_AUTO;
		apb(1'b1, light_range_pkg::ADDR_CTRL, {18'h0_0000, ctrl}, 1'b0, 32'h0);
		starts(48, 1'b0);
		for (int c = 0; c < 4; c++)
		begin
			apb(1'b0, 8'(rb + 8*c), 32'h0, 1'b0, {8'h00, need[c*4 +: 4], 20'h8_0000});
			apb(1'b0, 8'(rb + 8*c + 4), 32'h0, 1'b0,
				{4'h0, 28'h008_0000 << need[c*4 +: 4]});
		end
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
